// [e3_framer_params.svh]
// Constants of the E3 overhead framer: offsets, resets, geometry, timing
`ifndef E3_FRAMER_PARAMS_SVH
`define E3_FRAMER_PARAMS_SVH

// Register byte offsets
`define LFC_OFFSET         8'h00
`define IRQ_STATUS_OFFSET  8'h04
`define IRQ_MASK_OFFSET    8'h08
`define RX_STATE_OFFSET    8'h0C
`define TX_OH_OFFSET       8'h10
`define TRACE_OFFSET       8'h40
`define TRACE_WORDS        4

// Reset values
`define LFC_RESET          8'h00
`define IRQ_MASK_RESET     4'h0
`define TX_OH_RESET        24'h000000

// Mode field positions
`define LFC_LINE_TYPE_BIT  6
`define LFC_FORMAT_BIT     2

// Status event bit positions
`define EV_LOCK_BIT        0
`define EV_LOSS_BIT        1
`define EV_PARITY_BIT      2
`define EV_FAR_ERR_BIT     3
`define EV_COUNT           4

// Frame geometry
`define ALIGN1_VALUE       8'hF6
`define ALIGN2_VALUE       8'h28
`define ROW_COUNT          9
`define LONG_ROW_COLS      60
`define SHORT_ROW_COLS     59
`define FIRST_SHORT_ROW    6
`define FRAME_BYTES        537
`define PARITY_ROW         1
`define PATHID_ROW         2
`define FARSTAT_ROW        3
`define OPER_ROW           4
`define GENCH_ROW          5
`define REMOTE_ERR_BIT     6

// Path trace
`define TRACE_LEN          16
`define CRC7_POLY          7'h09

// Frame timing: byte rate from frame rate, fractional accumulator
`define FRAME_RATE_HZ      8000
`define CLOCK_RATE_KHZ     125000
`define BYTE_STEP          (`FRAME_BYTES * `FRAME_RATE_HZ / 1000)

`endif

// [e3_framer_pkg.sv]
// Types shared by the E3 overhead framer
package e3_framer_pkg;

   typedef enum logic [2:0] {
      OH_PAYLOAD, OH_ALIGN1, OH_ALIGN2, OH_PARITY,
      OH_PATHID, OH_FARSTAT, OH_OPER, OH_GENCH
   } ohKind_t;

   typedef enum logic {HUNT, LOCKED} rxState_t;

   typedef struct packed {
      logic [3:0] row;
      logic [5:0] col;
   } pos_t;

   typedef struct packed {
      logic       toggle;
      logic [7:0] data;
   } lineByte_t;

endpackage : e3_framer_pkg

// [e3_g832_overhead_framer.sv]
// E3 537-byte frame overhead framer with AHB-Lite register slave
//
// Contract
// - Mode on: type bit 6 zero, format bit 2 one
// - Frame is 537 bytes: 7 overhead
// - Nine rows; last three rows 59 columns
// - 8000 frames per second line rate
// - Seven overhead bytes in fixed slots
// - Send and hunt alignment pair F6 28
// - Parity of frame sent next frame
// - Bitwise even parity over all octets
// - Match: frame good, send flag zero
// - Mismatch: frame errored, send flag one
// - Path identifier sent repeatedly in trace
// - Trace 16 bytes, marker MSB one
// - Marker low bits: CRC-7 previous string
// - Fifteen characters with bit 7 zero
// - Remote error flag at status bit 6
//
// Added by the designer: the AHB-Lite register port.
`include "e3_framer_params.svh"
`timescale 1ns/1ps
`default_nettype none

module e3_g832_overhead_framer (
   input  wire logic        clock,
   input  wire logic        rstn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic [31:0]      hrdata,
   output logic             hresp,
   input  wire logic [7:0]  txPayload,
   output logic             txPayloadTake,
   output logic [7:0]       txLineByte,
   output logic             txLineValid,
   input  wire logic [7:0]  rxLineByte,
   input  wire logic        rxLineToggle,
   output logic [7:0]       rxPayload,
   output logic             rxPayloadValid,
   output logic             rxInFrame,
   output logic             irq
);

   ////////////////////////////////////////////////////////////////////////
   // Functions

   function automatic e3_framer_pkg::ohKind_t kindAt(
      input e3_framer_pkg::pos_t p);
      kindAt = e3_framer_pkg::OH_PAYLOAD;
      if (p.row == 4'd0 && p.col == 6'd0) begin
         kindAt = e3_framer_pkg::OH_ALIGN1;
      end else if (p.row == 4'd0 && p.col == 6'd1) begin
         kindAt = e3_framer_pkg::OH_ALIGN2;
      end else if (p.col == 6'd0) begin
         case (p.row)
            4'(`PARITY_ROW):  kindAt = e3_framer_pkg::OH_PARITY;
            4'(`PATHID_ROW):  kindAt = e3_framer_pkg::OH_PATHID;
            4'(`FARSTAT_ROW): kindAt = e3_framer_pkg::OH_FARSTAT;
            4'(`OPER_ROW):    kindAt = e3_framer_pkg::OH_OPER;
            4'(`GENCH_ROW):   kindAt = e3_framer_pkg::OH_GENCH;
            default:          kindAt = e3_framer_pkg::OH_PAYLOAD;
         endcase
      end
   endfunction : kindAt

   function automatic logic isLast(input e3_framer_pkg::pos_t p);
      isLast = (p.row == 4'(`ROW_COUNT - 1))
             && (p.col == 6'(`SHORT_ROW_COLS - 1));
   endfunction : isLast

   function automatic e3_framer_pkg::pos_t nextPos(
      input e3_framer_pkg::pos_t p);
      logic [5:0] rowEnd;
      rowEnd = (p.row >= 4'(`FIRST_SHORT_ROW)) ? 6'(`SHORT_ROW_COLS - 1)
                                              : 6'(`LONG_ROW_COLS - 1);
      nextPos = p;
      if (p.col == rowEnd) begin
         nextPos.col = 6'd0;
         nextPos.row = isLast(p) ? 4'd0 : p.row + 4'd1;
      end else begin
         nextPos.col = p.col + 6'd1;
      end
   endfunction : nextPos

   function automatic logic [6:0] crc7(input logic [6:0] c,
                                      input logic [7:0] b);
      logic [6:0] r;
      logic       fb;
      r = c;
      for (int i = 7; i >= 0; i--) begin
         fb = r[6] ^ b[i];
         r  = {r[5:0], 1'b0} ^ (fb ? `CRC7_POLY : 7'h00);
      end
      crc7 = r;
   endfunction : crc7

   ////////////////////////////////////////////////////////////////////////
   // Register bus

   logic [7:0]              lfc_q;
   logic [`EV_COUNT-1:0]    stat_q;
   logic [`EV_COUNT-1:0]    mask_q;
   logic [23:0]             txOh_q;
   logic [6:0]              traceMem [`TRACE_LEN];
   logic [7:0]              wrAddr_q;
   logic                    wrEn_q;
   logic [31:0]             hrdata_q;
   logic [`EV_COUNT-1:0]    events;
   logic                    rxLocked;
   logic                    remoteErr_q;
   logic                    farErrRx_q;
   logic [7:0]              rxParityByte_q;

   wire        addrPhase = hsel && htrans[1] && hready;
   wire        rdPhase   = addrPhase && !hwrite;
   wire [7:0]  rdAddr    = haddr[7:0];
   wire        rdStatus  = rdPhase && (rdAddr == `IRQ_STATUS_OFFSET);
   wire        framerOn  = !lfc_q[`LFC_LINE_TYPE_BIT]
                         && lfc_q[`LFC_FORMAT_BIT];
   wire [31:0] traceWord [`TRACE_WORDS];

   genvar gw;
   generate
      for (gw = 0; gw < `TRACE_WORDS; gw++) begin : g_tw
         assign traceWord[gw] = {1'b0, traceMem[4*gw+3],
                                 1'b0, traceMem[4*gw+2],
                                 1'b0, traceMem[4*gw+1],
                                 1'b0, traceMem[4*gw]};
      end
   endgenerate

   wire        rdTrace = (rdAddr[7:4] == `TRACE_OFFSET >> 4)
                       && (rdAddr[1:0] == 2'b00);
   wire [31:0] rdMux =
      (rdAddr == `LFC_OFFSET)        ? {24'h000000, lfc_q} :
      (rdAddr == `IRQ_STATUS_OFFSET) ? {28'h0000000, stat_q} :
      (rdAddr == `IRQ_MASK_OFFSET)   ? {28'h0000000, mask_q} :
      (rdAddr == `RX_STATE_OFFSET)   ? {16'h0000, rxParityByte_q,
                                        5'h00, farErrRx_q, remoteErr_q,
                                        rxLocked} :
      (rdAddr == `TX_OH_OFFSET)      ? {8'h00, txOh_q} :
      rdTrace                        ? traceWord[rdAddr[3:2]] :
                                       32'h00000000;

   always_ff @(posedge clock) begin
      if (!rstn) begin
         wrEn_q   <= 1'b0;
         wrAddr_q <= 8'h00;
         hrdata_q <= 32'h00000000;
      end else begin
         wrEn_q   <= addrPhase && hwrite;
         wrAddr_q <= addrPhase ? haddr[7:0] : wrAddr_q;
         hrdata_q <= rdPhase ? rdMux : hrdata_q;
      end
   end

   wire wrLfc  = wrEn_q && (wrAddr_q == `LFC_OFFSET);
   wire wrMask = wrEn_q && (wrAddr_q == `IRQ_MASK_OFFSET);
   wire wrTxOh = wrEn_q && (wrAddr_q == `TX_OH_OFFSET);

   always_ff @(posedge clock) begin
      if (!rstn) begin
         lfc_q  <= `LFC_RESET;
         mask_q <= `IRQ_MASK_RESET;
         txOh_q <= `TX_OH_RESET;
         stat_q <= '0;
      end else begin
         lfc_q  <= wrLfc ? hwdata[7:0] : lfc_q;
         mask_q <= wrMask ? hwdata[`EV_COUNT-1:0] : mask_q;
         txOh_q <= wrTxOh ? hwdata[23:0] : txOh_q;
         stat_q <= (rdStatus ? '0 : stat_q) | events;
      end
   end

   genvar gt;
   generate
      for (gt = 0; gt < `TRACE_LEN; gt++) begin : g_trace
         always_ff @(posedge clock) begin
            if (!rstn) begin
               traceMem[gt] <= 7'h00;
            end else if (wrEn_q && wrAddr_q == 8'(`TRACE_OFFSET + 4*(gt/4)))
            begin
               traceMem[gt] <= hwdata[8*(gt%4) +: 7];
            end
         end
      end
   endgenerate

   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = hrdata_q;
   assign irq       = |(stat_q & mask_q);

   ////////////////////////////////////////////////////////////////////////
   // Byte rate

   logic [16:0] rateAcc_q;
   wire  [17:0] rateSum  = {1'b0, rateAcc_q} + 18'(`BYTE_STEP);
   wire         byteTick = framerOn && (rateSum >= 18'(`CLOCK_RATE_KHZ));

   always_ff @(posedge clock) begin
      if (!rstn || !framerOn) begin
         rateAcc_q <= 17'h00000;
      end else begin
         rateAcc_q <= byteTick ? 17'(rateSum - 18'(`CLOCK_RATE_KHZ))
                               : rateSum[16:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Transmit

   e3_framer_pkg::pos_t    txPos_q;
   logic [7:0]             txBip_q;
   logic [7:0]             txBipPrev_q;
   logic [3:0]             traceIdx_q;
   logic [6:0]             crcRun_q;
   logic [6:0]             crcPrev_q;
   logic [7:0]             txByte_q;
   logic                   txValid_q;

   wire e3_framer_pkg::ohKind_t txKind = kindAt(txPos_q);
   wire [7:0] traceByte = (traceIdx_q == 4'd0)
                        ? {1'b1, crcPrev_q}
                        : {1'b0, traceMem[traceIdx_q]};
   wire [7:0] farStat   = {txOh_q[23], remoteErr_q,
                           txOh_q[21:16]};
   wire [7:0] txByte =
      (txKind == e3_framer_pkg::OH_ALIGN1)  ? `ALIGN1_VALUE :
      (txKind == e3_framer_pkg::OH_ALIGN2)  ? `ALIGN2_VALUE :
      (txKind == e3_framer_pkg::OH_PARITY)  ? txBipPrev_q :
      (txKind == e3_framer_pkg::OH_PATHID)  ? traceByte :
      (txKind == e3_framer_pkg::OH_FARSTAT) ? farStat :
      (txKind == e3_framer_pkg::OH_OPER)    ? txOh_q[7:0] :
      (txKind == e3_framer_pkg::OH_GENCH)   ? txOh_q[15:8] :
                                              txPayload;
   wire       txFirst = (txPos_q.row == 4'd0) && (txPos_q.col == 6'd0);
   wire [7:0] txBipNext = (txFirst ? 8'h00 : txBip_q) ^ txByte;
   wire       txTrace   = byteTick && (txKind == e3_framer_pkg::OH_PATHID);
   wire [6:0] crcNext   = crc7((traceIdx_q == 4'd0) ? 7'h00 : crcRun_q,
                               traceByte);

   assign txPayloadTake = byteTick && (txKind == e3_framer_pkg::OH_PAYLOAD);

   always_ff @(posedge clock) begin
      if (!rstn || !framerOn) begin
         txPos_q     <= '0;
         txBip_q     <= 8'h00;
         txBipPrev_q <= 8'h00;
         txByte_q    <= 8'h00;
         txValid_q   <= 1'b0;
      end else begin
         txValid_q <= byteTick;
         if (byteTick) begin
            txPos_q  <= nextPos(txPos_q);
            txByte_q <= txByte;
            txBip_q  <= txBipNext;
            if (isLast(txPos_q)) begin
               txBipPrev_q <= txBipNext;
            end
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!rstn) begin
         traceIdx_q <= 4'h0;
         crcRun_q   <= 7'h00;
         crcPrev_q  <= 7'h00;
      end else if (txTrace) begin
         traceIdx_q <= traceIdx_q + 4'd1;
         crcRun_q   <= crcNext;
         if (traceIdx_q == 4'(`TRACE_LEN - 1)) begin
            crcPrev_q <= crcNext;
         end
      end
   end

   assign txLineByte  = txByte_q;
   assign txLineValid = txValid_q;

   ////////////////////////////////////////////////////////////////////////
   // Receive

   e3_framer_pkg::lineByte_t rxMeta_q;
   e3_framer_pkg::lineByte_t rxSync_q;
   logic                     rxTogPrev_q;
   e3_framer_pkg::rxState_t  rxState_q;
   e3_framer_pkg::pos_t      rxPos_q;
   logic [7:0]               rxPrev_q;
   logic [7:0]               rxBip_q;
   logic [7:0]               rxBipPrev_q;
   logic                     rxHavePrev_q;
   logic [7:0]               rxPayload_q;
   logic                     rxPayloadValid_q;

   always_ff @(posedge clock) begin
      if (!rstn) begin
         rxMeta_q    <= '0;
         rxSync_q    <= '0;
         rxTogPrev_q <= 1'b0;
      end else begin
         rxMeta_q    <= '{toggle: rxLineToggle, data: rxLineByte};
         rxSync_q    <= rxMeta_q;
         rxTogPrev_q <= rxSync_q.toggle;
      end
   end

   wire       rxStrobe = framerOn && (rxSync_q.toggle != rxTogPrev_q);
   wire [7:0] rxByte   = rxSync_q.data;
   wire e3_framer_pkg::ohKind_t rxKind = kindAt(rxPos_q);
   wire       rxFirst  = (rxPos_q.row == 4'd0) && (rxPos_q.col == 6'd0);
   wire [7:0] rxBipNext = (rxFirst ? 8'h00 : rxBip_q) ^ rxByte;
   wire       huntHit  = (rxState_q == e3_framer_pkg::HUNT)
                       && (rxPrev_q == `ALIGN1_VALUE)
                       && (rxByte == `ALIGN2_VALUE);
   wire       alignBad = (rxState_q == e3_framer_pkg::LOCKED)
      && (((rxKind == e3_framer_pkg::OH_ALIGN1) && rxByte != `ALIGN1_VALUE)
      || ((rxKind == e3_framer_pkg::OH_ALIGN2) && rxByte != `ALIGN2_VALUE));
   wire       rxCheck  = (rxState_q == e3_framer_pkg::LOCKED) && rxHavePrev_q
                       && (rxKind == e3_framer_pkg::OH_PARITY);
   wire       rxMismatch = rxByte != rxBipPrev_q;
   wire       rxFarStat  = (rxState_q == e3_framer_pkg::LOCKED)
                         && (rxKind == e3_framer_pkg::OH_FARSTAT);

   assign rxLocked = (rxState_q == e3_framer_pkg::LOCKED);
   assign events[`EV_LOCK_BIT]    = rxStrobe && huntHit;
   assign events[`EV_LOSS_BIT]    = rxStrobe && alignBad;
   assign events[`EV_PARITY_BIT]  = rxStrobe && rxCheck && rxMismatch;
   assign events[`EV_FAR_ERR_BIT] = rxStrobe && rxFarStat
                                  && rxByte[`REMOTE_ERR_BIT];

   always_ff @(posedge clock) begin
      if (!rstn || !framerOn) begin
         rxState_q    <= e3_framer_pkg::HUNT;
         rxPos_q      <= '0;
         rxPrev_q     <= 8'h00;
         rxBip_q      <= 8'h00;
         rxBipPrev_q  <= 8'h00;
         rxHavePrev_q <= 1'b0;
      end else if (rxStrobe) begin
         rxPrev_q <= rxByte;
         case (rxState_q)
            e3_framer_pkg::HUNT: begin
               rxHavePrev_q <= 1'b0;
               if (huntHit) begin
                  rxState_q <= e3_framer_pkg::LOCKED;
                  rxPos_q   <= '{row: 4'd0, col: 6'd2};
                  rxBip_q   <= `ALIGN1_VALUE ^ `ALIGN2_VALUE;
               end
            end
            e3_framer_pkg::LOCKED: begin
               if (alignBad) begin
                  rxState_q    <= e3_framer_pkg::HUNT;
                  rxHavePrev_q <= 1'b0;
               end else begin
                  rxPos_q <= nextPos(rxPos_q);
                  rxBip_q <= rxBipNext;
                  if (isLast(rxPos_q)) begin
                     rxBipPrev_q  <= rxBipNext;
                     rxHavePrev_q <= 1'b1;
                  end
               end
            end
            default: rxState_q <= e3_framer_pkg::HUNT;
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (!rstn) begin
         remoteErr_q      <= 1'b0;
         farErrRx_q       <= 1'b0;
         rxParityByte_q   <= 8'h00;
         rxPayload_q      <= 8'h00;
         rxPayloadValid_q <= 1'b0;
      end else begin
         rxPayloadValid_q <= rxStrobe && rxLocked
                          && (rxKind == e3_framer_pkg::OH_PAYLOAD);
         if (rxStrobe && rxLocked) begin
            rxPayload_q <= rxByte;
         end
         if (rxStrobe && rxCheck) begin
            remoteErr_q    <= rxMismatch;
            rxParityByte_q <= rxByte;
         end
         if (rxStrobe && rxFarStat) begin
            farErrRx_q <= rxByte[`REMOTE_ERR_BIT];
         end
      end
   end

   assign rxPayload      = rxPayload_q;
   assign rxPayloadValid = rxPayloadValid_q;
   assign rxInFrame      = rxLocked;

endmodule : e3_g832_overhead_framer

`default_nettype wire

// [e3_framer_props.sv]
// Port checker for the E3 overhead framer
`include "e3_framer_params.svh"
`timescale 1ns/1ps
`default_nettype none

module e3_framer_props (
   input wire logic        clock,
   input wire logic        rstn,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic        txPayloadTake,
   input wire logic [7:0]  txLineByte,
   input wire logic        txLineValid,
   input wire logic        rxPayloadValid,
   input wire logic        rxInFrame
);
   logic [9:0] pos_q;
   logic [3:0] frame_q;
   logic [7:0] bip_q;
   logic [7:0] last_q;
   logic [5:0] gap_q;
   logic       seen_q;
   logic       wrMode_q;
   logic       modeOn_q;
   wire        modeAddr = hsel && htrans[1] && hready && hwrite
                          && haddr[7:0] == `LFC_OFFSET;
   wire        lastByte = pos_q == 10'(`FRAME_BYTES - 1);
   wire        ohSlot   = pos_q < 10'h2 || pos_q == 10'h3C
                          || pos_q == 10'h78 || pos_q == 10'hB4
                          || pos_q == 10'hF0 || pos_q == 10'h12C;

   ////////////////////////////////
   // Mode tracked from bus writes
   always_ff @(posedge clock) begin
      if (!rstn) begin
         wrMode_q <= 1'h0;
         modeOn_q <= 1'h0;
      end else begin
         wrMode_q <= modeAddr;
         if (wrMode_q)
            modeOn_q <= !hwdata[`LFC_LINE_TYPE_BIT]
                        && hwdata[`LFC_FORMAT_BIT];
      end
   end

   // Frame position, parity and byte gap
   always_ff @(posedge clock) begin
      if (!rstn || !modeOn_q) begin
         pos_q   <= 10'h0;
         frame_q <= 4'h0;
         bip_q   <= 8'h0;
         last_q  <= 8'h0;
         seen_q  <= 1'h0;
      end else if (txLineValid) begin
         seen_q <= 1'h1;
         pos_q  <= lastByte ? 10'h0 : pos_q + 10'h1;
         bip_q  <= lastByte ? 8'h0 : bip_q ^ txLineByte;
         if (lastByte)
            last_q <= bip_q ^ txLineByte;
         if (lastByte)
            frame_q <= frame_q + 4'h1;
      end
   end

   always_ff @(posedge clock) begin
      if (!rstn || txLineValid)
         gap_q <= 6'h1;
      else if (gap_q != 6'h3F)
         gap_q <= gap_q + 6'h1;
   end

   ////////////////////////////////
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);

   a_mode_off_idle:
      assert property (!modeOn_q && !$past(modeOn_q) |-> !txLineValid)
      else $error("line byte sent while framer off");
   a_byte_spacing:
      assert property (txLineValid && seen_q |->
         gap_q == 6'h1D || gap_q == 6'h1E)
      else $error("line byte spacing wrong");
   a_align_pair:
      assert property (txLineValid && pos_q < 10'h2 |->
         txLineByte == (pos_q[0] ? `ALIGN2_VALUE : `ALIGN1_VALUE))
      else $error("alignment byte wrong");
   a_parity_byte:
      assert property (txLineValid && pos_q == 10'h3C |->
         txLineByte == last_q)
      else $error("parity byte wrong");
   a_trace_marker:
      assert property (txLineValid && pos_q == 10'h78 |->
         txLineByte[7] == (frame_q == 4'h0))
      else $error("trace marker bit wrong");
   a_payload_slot:
      assert property (txPayloadTake |=> txLineValid && !ohSlot)
      else $error("payload taken in overhead slot");
   a_take_pulse:
      assert property (txPayloadTake |=> !txPayloadTake)
      else $error("payload take too long");
   a_rx_aligned:
      assert property (rxPayloadValid |-> $past(rxInFrame))
      else $error("payload out while not aligned");
   a_rx_single:
      assert property (rxPayloadValid |=> !rxPayloadValid [*2])
      else $error("payload valid too long");
endmodule : e3_framer_props

bind e3_g832_overhead_framer e3_framer_props i_props (
   .clock          (clock),
   .rstn           (rstn),
   .hsel           (hsel),
   .haddr          (haddr),
   .htrans         (htrans),
   .hwrite         (hwrite),
   .hwdata         (hwdata),
   .hready         (hready),
   .txPayloadTake  (txPayloadTake),
   .txLineByte     (txLineByte),
   .txLineValid    (txLineValid),
   .rxPayloadValid (rxPayloadValid),
   .rxInFrame      (rxInFrame)
);
`default_nettype wire

// [e3_line_partner.sv]
// Line side model: loops each sent byte back to the receiver
`timescale 1ns/1ps
`default_nettype none

module e3_line_partner #(
   parameter int FLIP_A = 0,
   parameter int FLIP_B = 0
) (
   input  wire logic       clock,
   input  wire logic [7:0] txLineByte,
   input  wire logic       txLineValid,
   output var logic [7:0]  rxLineByte,
   output var logic        rxLineToggle
);
   int         sent_q = 0;
   logic [2:0] wait_q = 3'h0;

   initial begin
      rxLineByte   = 8'h00;
      rxLineToggle = 1'h0;
   end

   // Byte settles four clocks before its toggle
   always @(posedge clock) begin
      if (txLineValid === 1'h1) begin
         rxLineByte <= (sent_q == FLIP_A || sent_q == FLIP_B)
                       ? ~txLineByte : txLineByte;
         sent_q <= sent_q + 1;
         wait_q <= 3'h4;
      end else if (wait_q != 3'h0) begin
         wait_q <= wait_q - 3'h1;
         if (wait_q == 3'h1)
            rxLineToggle <= ~rxLineToggle;
      end
   end
endmodule : e3_line_partner
`default_nettype wire

// [testbench.sv]
// Self-checking bench of the E3 overhead framer
`include "e3_framer_params.svh"
`timescale 1ns/1ps
`default_nettype none
`define CHECK(got, exp) \
   begin \
      num_checks++; \
      if ((got) !== (exp)) begin \
         err_total++; \
         $display("ERROR t=%0t got=%0h exp=%0h", $time, (got), (exp)); \
      end \
   end

module testbench;
   typedef struct packed {
      logic        w;
      logic [7:0]  a;
      logic [31:0] d;
      logic [31:0] e;
   } row_t;

   logic        clock;
   logic        rstn = 1'h0;
   logic        hsel = 1'h0;
   logic [31:0] haddr = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'h0;
   logic [31:0] hwdata = 32'h0;
   logic [7:0]  txPayload = 8'h0;
   wire         hready;
   logic        hreadyout, hresp, txPayloadTake, txLineValid;
   logic        rxLineToggle, rxPayloadValid, rxInFrame, irq;
   logic [31:0] hrdata, rd;
   logic [7:0]  txLineByte, rxLineByte, rxPayload, expB;
   logic [7:0]  bip = 8'h0;
   logic [7:0]  lastBip = 8'h0;
   logic [7:0]  sentQ [$];
   int          err_total = 0;
   int          num_checks = 0;
   int          txCount = 0;
   int          pos, frm, n;
   row_t        rows [13] = '{
      '{1'h0, 8'h00, 32'h0, 32'h0}, '{1'h0, 8'h04, 32'h0, 32'h0},
      '{1'h0, 8'h08, 32'h0, 32'h0}, '{1'h0, 8'h0C, 32'h0, 32'h0},
      '{1'h0, 8'h10, 32'h0, 32'h0}, '{1'h1, 8'h00, 32'h44, 32'h44},
      '{1'h1, 8'h08, 32'hFFFFFFFF, 32'hF},
      '{1'h1, 8'h08, 32'h4, 32'h4},
      '{1'h1, 8'h10, 32'h00BF5AA5, 32'h00BF5AA5},
      '{1'h1, 8'h40, 32'hB3B2B1B0, 32'h33323130},
      '{1'h1, 8'h44, 32'hB7B6B5B4, 32'h37363534},
      '{1'h1, 8'h48, 32'hBBBAB9B8, 32'h3B3A3938},
      '{1'h1, 8'h4C, 32'hBFBEBDBC, 32'h3F3E3D3C}};

   assign hready = hreadyout;

   initial begin
      clock = 1'h0;
      forever #4 clock = ~clock;
   end

   e3_g832_overhead_framer i_dut (
      .clock(clock), .rstn(rstn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
      .hresp(hresp), .txPayload(txPayload), .txPayloadTake(txPayloadTake),
      .txLineByte(txLineByte), .txLineValid(txLineValid),
      .rxLineByte(rxLineByte), .rxLineToggle(rxLineToggle),
      .rxPayload(rxPayload), .rxPayloadValid(rxPayloadValid),
      .rxInFrame(rxInFrame), .irq(irq));

   // Corrupts one parity byte, then one alignment byte
   e3_line_partner #(.FLIP_A(`FRAME_BYTES * 2 + 60),
      .FLIP_B(`FRAME_BYTES * 4)) i_line (
      .clock(clock), .txLineByte(txLineByte), .txLineValid(txLineValid),
      .rxLineByte(rxLineByte), .rxLineToggle(rxLineToggle));

   task automatic test_done;
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : test_done

   task automatic ahb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r);
      @(posedge clock);
      hsel <= 1'h1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      @(posedge clock);
      while (hready !== 1'h1) @(posedge clock);
      hsel <= 1'h0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge clock);
      while (hready !== 1'h1) @(posedge clock);
      r = hrdata;
   endtask : ahb

   ////////////////////////////////
   always @(posedge clock) begin
      if (txPayloadTake === 1'h1) begin
         sentQ.push_back(txPayload);
         txPayload <= txPayload + 8'h1;
      end
      if (rxPayloadValid === 1'h1 && sentQ.size() > 0) begin
         expB = sentQ.pop_front();
         `CHECK(rxPayload, expB)
      end
      if (txLineValid === 1'h1) begin
         pos = txCount % `FRAME_BYTES;
         frm = txCount / `FRAME_BYTES;
         if (pos == 0) begin
            lastBip = bip;
            bip = 8'h0;
         end
         bip = bip ^ txLineByte;
         case (pos)
            0: `CHECK(txLineByte, `ALIGN1_VALUE)
            60: `CHECK(txLineByte, lastBip)
            120: `CHECK(txLineByte, frm == 0 ? 8'h80 : 8'h30 + 8'(frm))
            180: if (frm < 4) `CHECK(txLineByte, frm < 2 ? 8'hBF : 8'hFF)
            240: `CHECK(txLineByte, 8'hA5)
            300: `CHECK(txLineByte, 8'h5A)
            default: ;
         endcase
         txCount++;
      end
   end

   initial begin
      repeat (90000) @(posedge clock);
      err_total++;
      $display("ERROR t=%0t watchdog expired", $time);
      test_done();
   end

   initial begin
      repeat (8) @(posedge clock);
      rstn <= 1'h1;
      @(posedge clock);
      `CHECK({txLineValid, rxInFrame, irq, hresp, hreadyout}, 5'h1)
      foreach (rows[i]) begin
         if (rows[i].w)
            ahb(1'h1, rows[i].a, rows[i].d, rd);
         ahb(1'h0, rows[i].a, 32'h0, rd);
         `CHECK(rd, rows[i].e)
      end
      ahb(1'h1, 8'h2C, 32'hFFFFFFFF, rd);
      ahb(1'h0, 8'h2C, 32'h0, rd);
      `CHECK(rd, 32'h0)
      $display("register test done");
      repeat (200) @(posedge clock);
      `CHECK(txCount, 0)
      ahb(1'h1, `LFC_OFFSET, 32'h4, rd);
      for (n = 0; n < 2000 && rxInFrame !== 1'h1; n++) @(posedge clock);
      `CHECK(rxInFrame, 1'h1)
      ahb(1'h0, `IRQ_STATUS_OFFSET, 32'h0, rd);
      `CHECK(rd, 32'h1)
      `CHECK(irq, 1'h0)
      $display("lock test done");
      for (n = 0; n < 40000 && irq !== 1'h1; n++) @(posedge clock);
      `CHECK(irq, 1'h1)
      ahb(1'h0, `RX_STATE_OFFSET, 32'h0, rd);
      `CHECK(rd[1], 1'h1)
      ahb(1'h0, `IRQ_STATUS_OFFSET, 32'h0, rd);
      `CHECK(rd[2], 1'h1)
      repeat (2) @(posedge clock);
      `CHECK(irq, 1'h0)
      ahb(1'h1, `IRQ_MASK_OFFSET, 32'h8, rd);
      for (n = 0; n < 8000 && irq !== 1'h1; n++) @(posedge clock);
      `CHECK(irq, 1'h1)
      $display("parity test done");
      for (n = 0; n < 40000 && rxInFrame !== 1'h0; n++) @(posedge clock);
      `CHECK(rxInFrame, 1'h0)
      ahb(1'h0, `IRQ_STATUS_OFFSET, 32'h0, rd);
      `CHECK(rd[1], 1'h1)
      $display("alignment loss test done");
      test_done();
   end
endmodule : testbench
`default_nettype wire
